// ===== ubh_uart.sv
// serial port: transmit fifo, framing, receive holding stage and handshake lines
`timescale 1ns/1ps
`include "ubh_consts.svh"
module ubh_uart #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [15:0] baud_int_i,
    input wire logic [`UBH_DIV_FRAC_W-1:0] baud_frac_i,
    input wire logic data_bits8_i,
    input wire ubh_pkg::ubh_parity_t parity_i,
    input wire logic stop_bits2_i,
    input wire ubh_pkg::ubh_flow_t flow_mode_i,
    input wire logic [7:0] resume_char_i,
    input wire logic [7:0] pause_char_i,
    input wire logic terminal_ready_en_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic [1:0] rx_err_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic transmit_active_o,
    output logic receive_ready_n_o,
    input wire logic clear_to_transmit_n_i,
    output logic terminal_ready_n_o,
    input wire logic peer_ready_n_i,
    input wire logic carrier_detect_i,
    input wire logic ring_wake_i,
    input wire logic interface_cfg_bit0_i,
    input wire logic interface_cfg_bit1_i,
    output logic carrier_detect_o,
    output logic ring_wake_o,
    output logic uart_enabled_o,
    output logic i2c_enabled_o,
    output logic tx_paused_o
);
    import ubh_pkg::*;

    // ----------------------------------------------------------------
    // shared decode
    // ----------------------------------------------------------------
    // parity bit for a character, used by both directions
    function automatic logic par_of(input logic [7:0] d, input logic b8, input ubh_parity_t m);
        logic ones;
        ones = ^(b8 ? d : {1'b0, d[6:0]});
        case (m)
            UBH_PAR_ODD: par_of = ~ones;
            UBH_PAR_EVEN: par_of = ones;
            UBH_PAR_HIGH: par_of = 1'b1;
            default: par_of = 1'b0;
        endcase
    endfunction

    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic uart_en;
    logic i2c_en;
    ubh_tx_state_t tx_state;
    logic [7:0] tx_shift;
    logic tx_par;
    logic [2:0] tx_cnt;
    ubh_rx_state_t rx_state;
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    logic rx_perr;
    logic rx_pend;
    logic [7:0] rx_word;
    logic [1:0] rx_word_err;
    logic paused;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic tx_tick;
    logic rx_mid;
    logic fifo_rd_ready;

    // ----------------------------------------------------------------
    // pin synchronisers and mode straps
    // ----------------------------------------------------------------
    // every outside level passes two flops before anything reads it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync_a <= `UBH_SYNC_RST;
            sync_b <= `UBH_SYNC_RST;
        end else if (clk_en_i) begin
            sync_a <= {interface_cfg_bit1_i, interface_cfg_bit0_i, ring_wake_i,
                carrier_detect_i, peer_ready_n_i, clear_to_transmit_n_i, serial_in_i};
            sync_b <= sync_a;
        end
    end
    wire rxd = sync_b[`UBH_PIN_RXD];
    wire cts_s = sync_b[`UBH_PIN_CTS];
    wire dsr_s = sync_b[`UBH_PIN_DSR];
    assign carrier_detect_o = sync_b[`UBH_PIN_DCD];
    assign ring_wake_o = sync_b[`UBH_PIN_RI];

    // mode is taken from the straps after synchronisation, never at reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            uart_en <= 1'b0;
            i2c_en <= 1'b0;
        end else if (clk_en_i) begin
            uart_en <= sync_b[`UBH_PIN_CFG1];
            i2c_en <= sync_b[`UBH_PIN_CFG0];
        end
    end
    assign uart_enabled_o = uart_en;
    assign i2c_enabled_o = i2c_en;
    wire port_on = uart_en & (flow_mode_i != UBH_FLOW_OFF);

    // ----------------------------------------------------------------
    // transmit path
    // ----------------------------------------------------------------
    ubh_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .in_data_i(tx_data_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_rd_ready)
    );

    ubh_baud u_tx_baud (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .restart_i(tx_state == UBH_TX_LEAD),
        .div_int_i(baud_int_i),
        .div_frac_i(baud_frac_i),
        .bit_tick_o(tx_tick),
        .mid_tick_o()
    );

    // flow gates are checked only between characters, a frame always completes
    wire cts_block = (flow_mode_i == UBH_FLOW_RTS_CTS) & cts_s;
    wire dsr_block = (flow_mode_i == UBH_FLOW_DTR_DSR) & dsr_s;
    wire pause_char_block = (flow_mode_i == UBH_FLOW_XON_PAUSE_CHAR) & paused;
    wire tx_allow = port_on & ~cts_block & ~dsr_block & ~pause_char_block;
    assign fifo_rd_ready = (tx_state == UBH_TX_IDLE) & tx_allow;
    wire tx_take = fifo_rd_ready & fifo_valid;
    wire [2:0] data_last = data_bits8_i ? 3'h7 : 3'h6;
    wire has_par = (parity_i != UBH_PAR_NONE);
    assign transmit_active_o = (tx_state != UBH_TX_IDLE);
    // line level from the state registers; idle and stop bits are marks
    assign serial_out_o = (tx_state == UBH_TX_START) ? 1'b0 :
        (tx_state == UBH_TX_DATA) ? tx_shift[0] :
        (tx_state == UBH_TX_PAR) ? tx_par : 1'b1;

    // transmit sequencer: one lead clock, start, data lsb first, parity, stops
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_state <= UBH_TX_IDLE;
            tx_shift <= 8'h00;
            tx_par <= 1'b0;
            tx_cnt <= 3'h0;
        end else if (clk_en_i) begin
            case (tx_state)
                UBH_TX_IDLE: begin
                    if (tx_take) begin
                        tx_shift <= fifo_data;
                        tx_par <= par_of(fifo_data, data_bits8_i, parity_i);
                        tx_state <= UBH_TX_LEAD;
                    end
                end
                UBH_TX_LEAD: tx_state <= UBH_TX_START;
                UBH_TX_START: begin
                    if (tx_tick) begin
                        tx_cnt <= 3'h0;
                        tx_state <= UBH_TX_DATA;
                    end
                end
                UBH_TX_DATA: begin
                    if (tx_tick) begin
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_cnt <= tx_cnt + 3'h1;
                        if (tx_cnt == data_last) begin
                            tx_cnt <= 3'h0;
                            tx_state <= has_par ? UBH_TX_PAR : UBH_TX_STOP;
                        end
                    end
                end
                UBH_TX_PAR: if (tx_tick) tx_state <= UBH_TX_STOP;
                UBH_TX_STOP: begin
                    if (tx_tick) begin
                        tx_cnt <= tx_cnt + 3'h1;
                        if (tx_cnt == {2'h0, stop_bits2_i}) begin
                            tx_state <= UBH_TX_IDLE;
                        end
                    end
                end
                default: tx_state <= UBH_TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receive path
    // ----------------------------------------------------------------
    // a pending character blocks new starts, so the line is not sampled then
    wire rx_begin = (rx_state == UBH_RX_IDLE) & ~rxd & ~rx_pend & port_on;

    ubh_baud u_rx_baud (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .restart_i(rx_begin),
        .div_int_i(baud_int_i),
        .div_frac_i(baud_frac_i),
        .bit_tick_o(),
        .mid_tick_o(rx_mid)
    );

    wire [7:0] rx_char = data_bits8_i ? rx_shift : {1'b0, rx_shift[7:1]};
    wire rx_end = (rx_state == UBH_RX_STOP) & rx_mid;
    wire is_xon = (flow_mode_i == UBH_FLOW_XON_PAUSE_CHAR);
    wire flow_char = is_xon & ((rx_char == pause_char_i) | (rx_char == resume_char_i));
    wire rx_done = rx_end & ~flow_char;
    wire hold_pop = rx_valid_o & rx_ready_i;
    wire [1:0] rx_err_now = {~rxd, rx_perr};

    // receive sequencer, sampling each bit at its middle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_state <= UBH_RX_IDLE;
            rx_shift <= 8'h00;
            rx_cnt <= 3'h0;
            rx_perr <= 1'b0;
        end else if (clk_en_i) begin
            case (rx_state)
                UBH_RX_IDLE: if (rx_begin) rx_state <= UBH_RX_START;
                UBH_RX_START: begin
                    if (rx_mid) begin
                        // a glitch shorter than half a bit is not a start
                        rx_state <= rxd ? UBH_RX_IDLE : UBH_RX_DATA;
                        rx_cnt <= 3'h0;
                        rx_perr <= 1'b0;
                    end
                end
                UBH_RX_DATA: begin
                    if (rx_mid) begin
                        rx_shift <= {rxd, rx_shift[7:1]};
                        rx_cnt <= rx_cnt + 3'h1;
                        if (rx_cnt == data_last) begin
                            rx_state <= has_par ? UBH_RX_PAR : UBH_RX_STOP;
                        end
                    end
                end
                UBH_RX_PAR: begin
                    if (rx_mid) begin
                        rx_perr <= (rxd != par_of(rx_char, data_bits8_i, parity_i));
                        rx_state <= UBH_RX_STOP;
                    end
                end
                UBH_RX_STOP: if (rx_mid) rx_state <= UBH_RX_IDLE;
                default: rx_state <= UBH_RX_IDLE;
            endcase
        end
    end

    // holding stage plus a second slot in the shift side
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= 8'h00;
            rx_err_o <= 2'h0;
            rx_pend <= 1'b0;
            rx_word <= 8'h00;
            rx_word_err <= 2'h0;
        end else if (clk_en_i) begin
            if (rx_done) begin
                rx_word <= rx_char;
                rx_word_err <= rx_err_now;
            end
            if (rx_done && (!rx_valid_o || hold_pop)) begin
                rx_data_o <= rx_char;
                rx_err_o <= rx_err_now;
                rx_valid_o <= 1'b1;
            end else if (hold_pop && rx_pend) begin
                rx_data_o <= rx_word;
                rx_err_o <= rx_word_err;
                rx_pend <= 1'b0;
            end else if (rx_done) begin
                rx_pend <= 1'b1;
            end else if (hold_pop) begin
                rx_valid_o <= 1'b0;
            end
        end
    end

    // software pause state, driven by the peer's in-band characters
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            paused <= 1'b0;
        end else if (clk_en_i) begin
            if (!is_xon) paused <= 1'b0;
            else if (rx_end && rx_char == pause_char_i) paused <= 1'b1;
            else if (rx_end && rx_char == resume_char_i) paused <= 1'b0;
        end
    end
    assign tx_paused_o = paused;

    // ----------------------------------------------------------------
    // handshake outputs
    // ----------------------------------------------------------------
    wire rts_full = (flow_mode_i == UBH_FLOW_RTS_CTS) & rx_valid_o & rx_pend;
    assign receive_ready_n_o = ~port_on | rts_full;
    wire dtr_full = (flow_mode_i == UBH_FLOW_DTR_DSR) & rx_pend;
    assign terminal_ready_n_o = ~(port_on & terminal_ready_en_i) | dtr_full;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || !clk_en_i);

    property p_lead;
        $rose(transmit_active_o) |-> serial_out_o ##1 !serial_out_o;
    endproperty
    a_lead: assert property (p_lead) else $error("start bit not one clock after active");
    property p_idle_mark;
        (tx_state == UBH_TX_IDLE) |-> serial_out_o && !transmit_active_o;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("idle line not high");
    property p_cts_hold;
        (tx_state == UBH_TX_IDLE && flow_mode_i == UBH_FLOW_RTS_CTS && cts_s) |=> !transmit_active_o;
    endproperty
    a_cts_hold: assert property (p_cts_hold) else $error("sent while clear to send high");
    property p_dsr_hold;
        (tx_state == UBH_TX_IDLE && flow_mode_i == UBH_FLOW_DTR_DSR && dsr_s) |=> !transmit_active_o;
    endproperty
    a_dsr_hold: assert property (p_dsr_hold) else $error("sent while peer not ready");
    property p_rts_full;
        (flow_mode_i == UBH_FLOW_RTS_CTS && rx_done && rx_valid_o && !rx_ready_i)
            |=> receive_ready_n_o;
    endproperty
    a_rts_full: assert property (p_rts_full) else $error("ready held with both stages full");
    property p_rts_low;
        (port_on && !rx_pend) |-> !receive_ready_n_o;
    endproperty
    a_rts_low: assert property (p_rts_low) else $error("ready not asserted with room");
    property p_pause;
        (is_xon && rx_end && rx_char == pause_char_i) |=> tx_paused_o;
    endproperty
    a_pause: assert property (p_pause) else $error("pause character ignored");
    property p_no_parity;
        (tx_state == UBH_TX_DATA && tx_tick && tx_cnt == data_last && !has_par)
            |=> tx_state == UBH_TX_STOP;
    endproperty
    a_no_parity: assert property (p_no_parity) else $error("frame length wrong");
    property p_mode_off;
        (!uart_en && tx_state == UBH_TX_IDLE) |=> !transmit_active_o;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("sent with serial port strapped off");
endmodule

// ===== ubh_consts.svh
// timing counts, limits and reset values for the serial port block
// Contract
// - line rates from 1.2 kbaud to 12 Mbaud
// - bit period is operating clock divided down
// - divisor integer part accepts 4 through 40000
// - divisor carries a fraction in eighths
// - odd divisors are rounded to lower eighth
// - config pins select serial-only or shared mode
// - transmit_active leads start bit by one cycle
// - receive_ready_n low when data can be accepted
// - clear_to_transmit_n high pauses new characters
// - terminal_ready_n low when connected and accepting
// - peer_ready_n high blocks transmission
// - start, 7/8 data lsb first, parity, stop
// - parity none, odd, even, high or low
// - receive_ready_n high when both receive stages full
// - resume_char restarts, pause_char stops transmission
`ifndef UBH_CONSTS_SVH
`define UBH_CONSTS_SVH
// ----------------------------------------------------------------
// divisor limits and clocking
// ----------------------------------------------------------------
`define UBH_DIV_MIN 16'h0004
`define UBH_DIV_MAX 16'h9C40
`define UBH_DIV_FRAC_W 3
`define UBH_BAUD_MIN_HZ 1200
`define UBH_BAUD_MAX_HZ 12000000
`define UBH_OPCLK_NOM_HZ 48000000
`define UBH_CLK_PERIOD_NS 10
`define UBH_TXACT_LEAD_CYC 1
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UBH_RESUME_RST 8'h11
`define UBH_PAUSE_RST 8'h13
`define UBH_SYNC_RST 7'h07
// ----------------------------------------------------------------
// field positions in the synchronised pin vector
// ----------------------------------------------------------------
`define UBH_PIN_RXD 0
`define UBH_PIN_CTS 1
`define UBH_PIN_DSR 2
`define UBH_PIN_DCD 3
`define UBH_PIN_RI 4
`define UBH_PIN_CFG0 5
`define UBH_PIN_CFG1 6
`endif

// ===== ubh_pkg.sv
// types shared by the serial port block
package ubh_pkg;
    typedef enum logic [2:0] {
        UBH_PAR_NONE = 3'h0,
        UBH_PAR_ODD = 3'h1,
        UBH_PAR_EVEN = 3'h2,
        UBH_PAR_HIGH = 3'h3,
        UBH_PAR_LOW = 3'h4
    } ubh_parity_t;
    typedef enum logic [2:0] {
        UBH_FLOW_NONE = 3'h0,
        UBH_FLOW_RTS_CTS = 3'h1,
        UBH_FLOW_DTR_DSR = 3'h2,
        UBH_FLOW_XON_PAUSE_CHAR = 3'h3,
        UBH_FLOW_OFF = 3'h4
    } ubh_flow_t;
    typedef enum logic [5:0] {
        UBH_TX_IDLE = 6'h01,
        UBH_TX_LEAD = 6'h02,
        UBH_TX_START = 6'h04,
        UBH_TX_DATA = 6'h08,
        UBH_TX_PAR = 6'h10,
        UBH_TX_STOP = 6'h20
    } ubh_tx_state_t;
    typedef enum logic [4:0] {
        UBH_RX_IDLE = 5'h01,
        UBH_RX_START = 5'h02,
        UBH_RX_DATA = 5'h04,
        UBH_RX_PAR = 5'h08,
        UBH_RX_STOP = 5'h10
    } ubh_rx_state_t;
endpackage

// ===== ubh_fifo.sv
// small synchronous fifo with a registered output stage
`timescale 1ns/1ps
module ubh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] mcnt;
    // ----------------------------------------------------------------
    // handshake decode
    // ----------------------------------------------------------------
    // the output register counts as an extra slot, so DEPTH+1 words fit
    wire push = in_valid_i & in_ready_o;
    wire load = (mcnt != '0) & (~out_valid_o | out_ready_i);
    assign in_ready_o = (mcnt != (AW+1)'(DEPTH));
    // storage write and head prefetch
    always_ff @(posedge clk_i) begin
        if (clk_en_i) begin
            if (push) begin
                mem[wp] <= in_data_i;
            end
            if (load) begin
                out_data_o <= mem[rp];
            end
        end
    end
    // pointers, fill level and output valid
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wp <= '0;
            rp <= '0;
            mcnt <= '0;
            out_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            if (push) wp <= wp + 1'b1;
            if (load) rp <= rp + 1'b1;
            mcnt <= mcnt + (AW+1)'(push) - (AW+1)'(load);
            if (load) out_valid_o <= 1'b1;
            else if (out_ready_i) out_valid_o <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_fills_up;
        @(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        (push && !load && mcnt == (AW+1)'(DEPTH-1)) |=> !in_ready_o;
    endproperty
    a_fills_up: assert property (p_fills_up) else $error("fifo did not report full");
endmodule

// ===== ubh_baud.sv
// fractional bit-period generator with mid-bit strobe
`timescale 1ns/1ps
`include "ubh_consts.svh"
module ubh_baud (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic restart_i,
    input wire logic [15:0] div_int_i,
    input wire logic [`UBH_DIV_FRAC_W-1:0] div_frac_i,
    output logic bit_tick_o,
    output logic mid_tick_o
);
    logic [15:0] cnt;
    logic [`UBH_DIV_FRAC_W-1:0] acc;
    // ----------------------------------------------------------------
    // divisor decode
    // ----------------------------------------------------------------
    // out-of-range divisors are clamped rather than allowed to stall the line
    wire [15:0] div_eff = (div_int_i < `UBH_DIV_MIN) ? `UBH_DIV_MIN :
        (div_int_i > `UBH_DIV_MAX) ? `UBH_DIV_MAX : div_int_i;
    // the fraction is taken as given: software rounds down to an eighth
    wire [`UBH_DIV_FRAC_W:0] acc_sum = {1'b0, acc} + {1'b0, div_frac_i};
    // a carry stretches this bit by one clock, eight bits average out
    wire [15:0] period = div_eff + {15'h0000, acc_sum[`UBH_DIV_FRAC_W]};
    assign bit_tick_o = (cnt == period - 16'h0001);
    assign mid_tick_o = (cnt == {1'b0, div_eff[15:1]} - 16'h0001);
    // period counter and fraction accumulator
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt <= 16'h0000;
            acc <= '0;
        end else if (clk_en_i) begin
            if (restart_i) begin
                cnt <= 16'h0000;
                acc <= '0;
            end else if (bit_tick_o) begin
                cnt <= 16'h0000;
                acc <= acc_sum[`UBH_DIV_FRAC_W-1:0];
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_min_period;
        @(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        bit_tick_o |=> !bit_tick_o [*3];
    endproperty
    a_min_period: assert property (p_min_period) else $error("bit period under four clocks");
endmodule

// ===== ubh_peer.sv
// serial peer model: frame capture and frame send at a fixed divisor
`timescale 1ns/1ps
module ubh_peer #(
    parameter int DIV = 8
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    logic [9:0] q[$];
    logic [9:0] w;
    initial line_o = 1'b1;
    // capture ten bit times after each start edge, sampled mid-bit
    initial forever begin
        @(negedge line_i);
        repeat (DIV / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            repeat (DIV) @(posedge clk_i);
            w[i] = line_i;
        end
        q.push_back(w);
    end
    // start, eight data bits lsb first, one stop; line rests high after
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= f[i];
            repeat (DIV) @(posedge clk_i);
        end
    endtask
endmodule

// ===== ubh_uart_tb.sv
// self-checking bench for the serial port block
`timescale 1ns/1ps
module ubh_uart_tb;
    import ubh_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, clk_en_i = 1, data_bits8_i = 1, stop_bits2_i = 0;
    logic [15:0] baud_int_i = 16'h0008;
    logic [2:0] baud_frac_i = 3'h0;
    ubh_parity_t parity_i = UBH_PAR_NONE;
    ubh_flow_t flow_mode_i = UBH_FLOW_NONE;
    logic [7:0] resume_char_i = 8'h11, pause_char_i = 8'h13, tx_data_i = 8'h00, rx_data_o;
    logic terminal_ready_en_i = 1, tx_valid_i = 0, rx_ready_i = 0, clear_to_transmit_n_i = 0;
    logic peer_ready_n_i = 0, carrier_detect_i = 1, ring_wake_i = 0, interface_cfg_bit0_i = 1;
    logic interface_cfg_bit1_i = 1, serial_in_i, serial_out_o, transmit_active_o, tx_ready_o;
    logic rx_valid_o, receive_ready_n_o, terminal_ready_n_o, carrier_detect_o, ring_wake_o;
    logic uart_enabled_o, i2c_enabled_o, tx_paused_o, ta_q = 0;
    logic [1:0] rx_err_o;
    logic [7:0] d;
    int err_total = 0, n_checks = 0, cyc = 0, seed = 32'h12d8c60d;
    ubh_uart DUT (.*);
    ubh_peer #(.DIV(8)) peer (.clk_i(clk_i), .line_i(serial_out_o), .line_o(serial_in_i));
    initial forever #5 clk_i = ~clk_i;
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // frame the bench expects: data, parity slot (or stop), stop
    function automatic logic [9:0] frame(input logic [7:0] v, input int p);
        logic par;
        par = (p == 1) ? ~^v : (p == 2) ? ^v : (p == 4) ? 1'b0 : 1'b1;
        return {1'b1, par, v};
    endfunction
    // the wait is bounded so a stuck transmitter shows up as a mismatch
    task automatic push(input logic [7:0] v, input int lim);
        tx_data_i <= v;
        tx_valid_i <= 1;
        @(posedge clk_i);
        tx_valid_i <= 0;
        for (int i = 0; i < lim && peer.q.size() == 0; i++) @(posedge clk_i);
    endtask
    // lead cycle: the indicator must rise while the line is still idle
    always @(negedge clk_i) begin
        ta_q <= transmit_active_o;
        if (transmit_active_o === 1'b1 && ta_q === 1'b0) check("lead", serial_out_o, 10'h1);
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run;
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 0;
        repeat (6) @(posedge clk_i);
        check("mode", {uart_enabled_o, i2c_enabled_o}, 10'h3);
        check("ready", {receive_ready_n_o, terminal_ready_n_o}, 10'h0);
        for (int p = 0; p < 5; p++) begin
            for (int k = 0; k < 3; k++) begin
                d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
                parity_i <= ubh_parity_t'(p);
                stop_bits2_i <= k[0];
                @(posedge clk_i);
                push(d, 400);
                check("frame", peer.q.pop_front(), frame(d, p));
            end
        end
        parity_i <= UBH_PAR_NONE;
        for (int m = 1; m < 3; m++) begin
            flow_mode_i <= ubh_flow_t'(m);
            clear_to_transmit_n_i <= (m == 1);
            peer_ready_n_i <= (m == 2);
            d = 8'($random(seed));
            push(d, 300);
            check("held", 10'(peer.q.size()), 10'h0);
            clear_to_transmit_n_i <= 0;
            peer_ready_n_i <= 0;
            // the held word goes out by itself, a second push would leave a frame behind
            for (int i = 0; i < 400 && peer.q.size() == 0; i++) @(posedge clk_i);
            check("resumed", peer.q.pop_front(), frame(d, 0));
        end
        d = 8'($random(seed));
        peer.send(d);
        for (int i = 0; i < 40 && rx_valid_o !== 1'b1; i++) @(posedge clk_i);
        check("rx", {rx_err_o, rx_data_o}, {2'b00, d});
        check("carrier", carrier_detect_o, 10'h1);
        rx_ready_i <= 1;
        @(posedge clk_i);
        rx_ready_i <= 0;
        // in-band pause and resume, consumed rather than delivered
        flow_mode_i <= UBH_FLOW_XON_PAUSE_CHAR;
        ring_wake_i <= 1;
        @(posedge clk_i);
        peer.send(8'h13);
        repeat (4) @(posedge clk_i);
        check("paused", tx_paused_o, 10'h1);
        check("ring", ring_wake_o, 10'h1);
        peer.send(8'h11);
        repeat (4) @(posedge clk_i);
        check("resumed_flag", {rx_valid_o, tx_paused_o}, 10'h0);
        // seven data bits: stop then idle marks fill the captured slots
        flow_mode_i <= UBH_FLOW_NONE;
        data_bits8_i <= 0;
        d = 8'($random(seed));
        @(posedge clk_i);
        push(d, 400);
        check("frame7", peer.q.pop_front(), {3'b111, d[6:0]});
        complete_run;
    end
endmodule
